//--- core/pwr_ctrl_map.vh
`ifndef PWR_CTRL_MAP_VH
`define PWR_CTRL_MAP_VH
// APB register byte offsets
`define REG_CTRL      12'h000
`define REG_WAKE_EN   12'h004
`define REG_PORT_DIR  12'h008
`define REG_PORT_OUT  12'h00C
`define REG_PULLUP    12'h010
`define REG_PORT_IN   12'h014
`define REG_STATUS    12'h018
`define REG_IRQ_MASK  12'h01C
`define REG_WDT_CLR   12'h020
// Control register fields
`define CTRL_WDT_SEL_LO   0
`define CTRL_WDT_EN       2
`define CTRL_FAST_WAKE    3
`define CTRL_RST_PIN_EN   4
`define CTRL_LIGHT_CMD    5
`define CTRL_DEEP_CMD     6
`define CTRL_FAST_CLK     7
`define CTRL_RESET        8'h00
// Status bits
`define ST_EXT_IRQ0   0
`define ST_WAKE       1
`define ST_WDT        2
`define ST_EXT_RST    3
// Timing in slow / system clocks
`define BOOT_SLOW_CLKS    1024
`define NORM_WAKE_CLKS    1024
`define FAST_WAKE_CLKS    128
`define WDT_P0            2048
`define WDT_P1            4096
`define WDT_P2            16384
`define WDT_P3            256
`endif

//--- core/sleep_wakeup_watchdog_ctrl.v
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_ctrl_map.vh"

// Summary of operation
// - Disabled pin wake bit blocks its wake-up
// - Bit five: input/open-drain, no pull-up, reset option
// - Other bits: input or output, optional pull-up
// - Line zero interrupts on both edges
// - Watchdog period select 2048/4096/16384/256 slow clocks
// - Fast wake resumes after 128 clocks, plus startup only on deep exit with fast clock set
// - Normal wake waits 1024 slow clocks
// - Light suspend halts core, clocks keep running
// - Deep suspend gates system clock, memory kept
// - Power-on waits 1024 slow clocks before run
module sleep_wakeup_watchdog_ctrl #(
    parameter WDT_W        = 15,
    parameter FAST_OSC_SU  = 16
) (
    input  wire        pclk,          // Bus and system clock
    input  wire        presetn,       // Async reset, low active
    input  wire        psel,          // APB select
    input  wire        penable,       // APB enable
    input  wire        pwrite,        // APB direction
    input  wire [11:0] paddr,         // APB byte address
    input  wire [31:0] pwdata,        // APB write data
    output wire [31:0] prdata,        // APB read data
    output wire        pready,        // APB ready
    output wire        pslverr,       // APB error
    input  wire        slow_rc_tick,  // One pulse per slow osc clock
    input  wire [7:0]  port_in,       // Pin levels
    output wire [7:0]  port_out,      // Pin drive values
    output wire [7:0]  port_oe,       // Pin drive enables
    output wire [7:0]  port_pullup,   // Pull-up enables
    output wire        core_run,      // Core may execute
    output wire        sys_clk_en,    // System clock gate
    output wire        fast_rc_osc_en, // Fast oscillator on
    output wire        slow_rc_osc_en, // Slow oscillator on
    output wire        timer_run,     // Timer keeps counting
    output wire        chip_reset,    // Reset to the core
    output wire        irq            // Level interrupt
);
    localparam ST_BOOT  = 3'd0;
    localparam ST_RUN   = 3'd1;
    localparam ST_LIGHT = 3'd2;
    localparam ST_DEEP  = 3'd3;
    localparam ST_WFAST = 3'd4;
    localparam ST_WSLOW = 3'd5;

    reg  [7:0]  ctrl_r;
    reg  [7:0]  wake_en_r;
    reg  [7:0]  dir_r;
    reg  [7:0]  out_r;
    reg  [7:0]  pull_r;
    reg  [3:0]  status_r;
    reg  [3:0]  mask_r;
    reg  [7:0]  pin_prev_r;
    reg  [2:0]  state_r;
    reg  [10:0] cnt_r;
    reg  [WDT_W-1:0] wdt_r;
    reg  [31:0] rdata_r;
    reg         wdt_clr_r;
    reg         was_deep_r;

    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;
    // Read data is captured in setup so it stands through the access edge
    wire rd_setup = psel & ~penable & ~pwrite;
    wire mapped = (paddr <= `REG_WDT_CLR) && (paddr[1:0] == 2'b00);

    function [WDT_W-1:0] wdt_limit;
        input [1:0] sel;
        reg   [31:0] lim;
        begin
            case (sel)
                2'b00:   lim = `WDT_P0;
                2'b01:   lim = `WDT_P1;
                2'b10:   lim = `WDT_P2;
                default: lim = `WDT_P3;
            endcase
            wdt_limit = lim[WDT_W-1:0];
        end
    endfunction

    wire [7:0] toggled = port_in ^ pin_prev_r;
    wire       wake_hit = |(toggled & wake_en_r);
    wire       irq0_edge = toggled[0];
    wire       ext_rst = ctrl_r[`CTRL_RST_PIN_EN] & ~port_in[5];
    wire       wdt_exp = ctrl_r[`CTRL_WDT_EN] &
                         (wdt_r >= wdt_limit(ctrl_r[1:0]) - 1'b1);
    wire       wdt_fire = wdt_exp & slow_rc_tick;
    wire       sleeping = (state_r == ST_LIGHT) | (state_r == ST_DEEP);

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = rdata_r;
    assign irq     = |(status_r & mask_r);
    // Bit five never drives high; open-drain pulls low only
    assign port_out    = {out_r[7:6], 1'b0, out_r[4:0]};
    assign port_oe     = {dir_r[7:6], dir_r[5] & ~out_r[5] &
                          ~ctrl_r[`CTRL_RST_PIN_EN], dir_r[4:0]};
    assign port_pullup = {pull_r[7:6], 1'b0, pull_r[4:0]};
    assign core_run    = (state_r == ST_RUN);
    assign sys_clk_en  = (state_r != ST_DEEP);
    assign fast_rc_osc_en = (state_r != ST_DEEP);
    assign slow_rc_osc_en = 1'b1;
    assign timer_run   = (state_r != ST_DEEP);
    assign chip_reset  = (state_r == ST_BOOT);

    // Power state machine; reset sources restart the boot wait
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= ST_BOOT;
            cnt_r      <= 11'h000;
            was_deep_r <= 1'b0;
        end else if (wdt_fire | ext_rst) begin
            state_r <= ST_BOOT;
            cnt_r   <= 11'h000;
        end else begin
            case (state_r)
                ST_BOOT: begin
                    if (slow_rc_tick) begin
                        if (cnt_r == `BOOT_SLOW_CLKS - 1) begin
                            state_r <= ST_RUN;
                            cnt_r   <= 11'h000;
                        end else begin
                            cnt_r <= cnt_r + 11'h001;
                        end
                    end
                end
                ST_RUN: begin
                    cnt_r <= 11'h000;
                    if (wr && paddr == `REG_CTRL &&
                        pwdata[`CTRL_DEEP_CMD]) begin
                        state_r    <= ST_DEEP;
                        was_deep_r <= 1'b1;
                    end else if (wr && paddr == `REG_CTRL &&
                                 pwdata[`CTRL_LIGHT_CMD]) begin
                        state_r    <= ST_LIGHT;
                        was_deep_r <= 1'b0;
                    end
                end
                ST_LIGHT, ST_DEEP: begin
                    if (wake_hit) begin
                        state_r <= ctrl_r[`CTRL_FAST_WAKE] ?
                                   ST_WFAST : ST_WSLOW;
                    end
                end
                ST_WFAST: begin
                    // Deep exit with fast clock set adds fast oscillator start-up time
                    if (cnt_r == ((was_deep_r &&
                        ctrl_r[`CTRL_FAST_CLK]) ?
                        `FAST_WAKE_CLKS + FAST_OSC_SU - 1 :
                        `FAST_WAKE_CLKS - 1)) begin
                        state_r <= ST_RUN;
                        cnt_r   <= 11'h000;
                    end else begin
                        cnt_r <= cnt_r + 11'h001;
                    end
                end
                ST_WSLOW: begin
                    if (slow_rc_tick) begin
                        if (cnt_r == `NORM_WAKE_CLKS - 1) begin
                            state_r <= ST_RUN;
                            cnt_r   <= 11'h000;
                        end else begin
                            cnt_r <= cnt_r + 11'h001;
                        end
                    end
                end
                default: state_r <= ST_BOOT;
            endcase
        end
    end

    // Watchdog counts slow clocks in every state except boot, sleep and wake included
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_r     <= {WDT_W{1'b0}};
            wdt_clr_r <= 1'b0;
        end else begin
            wdt_clr_r <= wr && paddr == `REG_WDT_CLR;
            if (wdt_clr_r || !ctrl_r[`CTRL_WDT_EN] || state_r == ST_BOOT)
                wdt_r <= {WDT_W{1'b0}};
            else if (slow_rc_tick && !wdt_exp)
                wdt_r <= wdt_r + 1'b1;
        end
    end

    // Registers, status and read data
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= `CTRL_RESET;
            wake_en_r  <= 8'hFF;
            dir_r      <= 8'h00;
            out_r      <= 8'h00;
            pull_r     <= 8'h00;
            status_r   <= 4'h0;
            mask_r     <= 4'h0;
            pin_prev_r <= 8'h00;
            rdata_r    <= 32'h0000_0000;
        end else begin
            pin_prev_r <= port_in;
            if (wr) begin
                case (paddr)
                    `REG_CTRL:     ctrl_r    <= {2'b00, pwdata[5:0]} |
                                                {pwdata[7], 7'h00};
                    `REG_WAKE_EN:  wake_en_r <= pwdata[7:0];
                    `REG_PORT_DIR: dir_r     <= pwdata[7:0];
                    `REG_PORT_OUT: out_r     <= pwdata[7:0];
                    `REG_PULLUP:   pull_r    <= pwdata[7:0];
                    `REG_IRQ_MASK: mask_r    <= pwdata[3:0];
                    default: ;
                endcase
            end
            if (wr && paddr == `REG_CTRL)
                ctrl_r[`CTRL_LIGHT_CMD] <= 1'b0;
            rdata_r <= 32'h0000_0000;
            if (rd_setup) begin
                case (paddr)
                    `REG_CTRL:     rdata_r <= {24'h000000,
                                               ctrl_r & 8'h9F};
                    `REG_WAKE_EN:  rdata_r <= {24'h000000, wake_en_r};
                    `REG_PORT_DIR: rdata_r <= {24'h000000, dir_r};
                    `REG_PORT_OUT: rdata_r <= {24'h000000, out_r};
                    `REG_PULLUP:   rdata_r <= {24'h000000, pull_r};
                    `REG_PORT_IN:  rdata_r <= {24'h000000, port_in};
                    `REG_STATUS:   rdata_r <= {28'h0000000, status_r};
                    `REG_IRQ_MASK: rdata_r <= {28'h0000000, mask_r};
                    default:       rdata_r <= 32'h0000_0000;
                endcase
            end
            // Read clears status; a new event in that cycle still sets
            status_r <= (rd && paddr == `REG_STATUS) ? 4'h0 : status_r;
            if (irq0_edge) status_r[`ST_EXT_IRQ0] <= 1'b1;
            if (wake_hit && sleeping) status_r[`ST_WAKE] <= 1'b1;
            if (wdt_fire) status_r[`ST_WDT] <= 1'b1;
            if (ext_rst) status_r[`ST_EXT_RST] <= 1'b1;
        end
    end
endmodule // sleep_wakeup_watchdog_ctrl
`default_nettype wire

//--- testbench/pin_board.sv
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    input  wire logic [7:0] port_out, // Device drive values
    input  wire logic [7:0] port_oe,  // Device drive enables
    input  wire logic [7:0] board,    // Board drive values
    output wire logic [7:0] port_in   // Pin levels seen
);
    // Device drive wins over the board's weak drive
    assign port_in = (port_oe & port_out) | (~port_oe & board);
endmodule // pin_board
`default_nettype wire

//--- testbench/swwc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module swwc_asserts (
    input wire logic       pclk,           // Clock
    input wire logic       presetn,        // Reset
    input wire logic       slow_rc_tick,   // Slow tick
    input wire logic [7:0] port_out,       // Drive values
    input wire logic [7:0] port_pullup,    // Pull-ups
    input wire logic       core_run,       // Core runs
    input wire logic       sys_clk_en,     // Clock gate
    input wire logic       fast_rc_osc_en, // Fast osc
    input wire logic       slow_rc_osc_en, // Slow osc
    input wire logic       timer_run,      // Timer
    input wire logic       chip_reset      // Core reset
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [10:0] boot_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            boot_r <= 11'h000;
        else if (!chip_reset)
            boot_r <= 11'h000;
        else if (slow_rc_tick && !boot_r[10])
            boot_r <= boot_r + 11'h001;
    end
    AST_P5_NO_PULL: assert property (!port_pullup[5])
        else $error("pull-up on bit five");
    AST_P5_OPEN_DRAIN: assert property (!port_out[5])
        else $error("bit five drives high");
    AST_DEEP_GATES: assert property (!sys_clk_en |-> !fast_rc_osc_en && !timer_run)
        else $error("deep suspend left clocks on");
    AST_DEEP_HALTS: assert property (!sys_clk_en |-> !core_run)
        else $error("core runs without clock");
    AST_LIGHT_KEEPS: assert property (sys_clk_en |-> timer_run && fast_rc_osc_en)
        else $error("clock or timer stopped");
    AST_SLOW_ON: assert property (slow_rc_osc_en)
        else $error("slow osc stopped");
    AST_BOOT_WAIT: assert property ($fell(chip_reset) |-> boot_r[10])
        else $error("boot wait too short");
    AST_BOOT_HALT: assert property (chip_reset |-> !core_run)
        else $error("core runs in reset");
    AST_WAKE_GAP: assert property ($fell(core_run) && !chip_reset |-> !core_run [*8])
        else $error("wake too soon");
    cover property ($fell(chip_reset));
    cover property (!sys_clk_en);
    cover property ($rose(core_run) && !$past(chip_reset));
endmodule // swwc_asserts
bind sleep_wakeup_watchdog_ctrl swwc_asserts u_chk (.pclk(pclk),
    .presetn(presetn), .slow_rc_tick(slow_rc_tick), .port_out(port_out),
    .port_pullup(port_pullup), .core_run(core_run), .sys_clk_en(sys_clk_en),
    .fast_rc_osc_en(fast_rc_osc_en), .slow_rc_osc_en(slow_rc_osc_en),
    .timer_run(timer_run), .chip_reset(chip_reset));
`default_nettype wire

//--- testbench/sleep_wakeup_watchdog_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_ctrl_map.vh"
module sleep_wakeup_watchdog_ctrl_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0]  bval = 8'hFF;
    logic [31:0] rd;
    logic        err;
    wire  [31:0] prdata;
    wire  [7:0]  port_in, port_out, port_oe, port_pullup;
    wire         pready, pslverr, core_run, sys_clk_en, irq, chip_reset;
    wire         fast_rc_osc_en, slow_rc_osc_en, timer_run;
    int          n_errors = 0;
    int          checks_done = 0;
    int          n;
    int          per [4] = '{2048, 4096, 16384, 256};
    always #25 pclk = ~pclk;
    // Tick every cycle keeps boot and watchdog waits short
    sleep_wakeup_watchdog_ctrl #(.FAST_OSC_SU(16)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slow_rc_tick(1'b1),
        .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
        .port_pullup(port_pullup), .core_run(core_run),
        .sys_clk_en(sys_clk_en), .fast_rc_osc_en(fast_rc_osc_en),
        .slow_rc_osc_en(slow_rc_osc_en), .timer_run(timer_run),
        .chip_reset(chip_reset), .irq(irq));
    pin_board board_u (.port_out(port_out), .port_oe(port_oe), .board(bval),
        .port_in(port_in));
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic fail;
        n_errors++;
        conclude();
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task automatic rng(input int lo, input int hi);
        chk({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask
    task automatic wt(input logic rst, input logic v, input int lim);
        n = 0;
        while ((rst ? chip_reset : core_run) !== v) begin
            @(negedge pclk);
            n++;
            if (n > lim) fail();
        end
    endtask
    task automatic pin(input logic [7:0] v);
        @(posedge pclk);
        bval <= v;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) fail();
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let register updates settle before callers look at outputs
        @(negedge pclk);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        wt(1, 0, 1100);
        rng(1023, 1027);
        apb(0, `REG_CTRL, 0);
        chk(rd, 32'h00000000);
        apb(0, `REG_WAKE_EN, 0);
        chk(rd, 32'h000000FF);
        apb(0, 12'h024, 0);
        chk({31'h0, err}, 32'h1);
        apb(1, `REG_PULLUP, 32'hFF);
        chk(port_pullup, 8'hDF);
        pin(8'h00);
        apb(1, `REG_PORT_DIR, 32'hFF);
        apb(1, `REG_PORT_OUT, 32'hFF);
        chk(port_oe, 8'hDF);
        apb(0, `REG_PORT_IN, 0);
        chk(rd, 32'h000000DF);
        apb(1, `REG_PORT_OUT, 32'h00);
        chk(port_oe, 8'hFF);
        apb(1, `REG_PORT_DIR, 32'h00);
        $display("boot and pin test done");
        apb(1, `REG_IRQ_MASK, 32'h0);
        apb(0, `REG_STATUS, 0);
        pin(8'h01);
        repeat (4) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1, `REG_IRQ_MASK, 32'h1);
        chk(irq, 1'b1);
        apb(0, `REG_STATUS, 0);
        chk(rd & 32'h1, 32'h1);
        chk(irq, 1'b0);
        pin(8'h00);
        repeat (4) @(posedge pclk);
        apb(0, `REG_STATUS, 0);
        chk(rd & 32'h1, 32'h1);
        $display("irq test done");
        apb(1, `REG_WAKE_EN, 32'hFE);
        apb(1, `REG_CTRL, 32'h28);
        chk({core_run, timer_run}, 2'b01);
        pin(8'h01);
        repeat (200) @(posedge pclk);
        chk(core_run, 1'b0);
        pin(8'h03);
        wt(0, 1, 300);
        rng(127, 132);
        apb(1, `REG_CTRL, 32'h20);
        pin(8'h01);
        wt(0, 1, 1100);
        rng(1023, 1028);
        apb(1, `REG_CTRL, 32'hC8);
        chk(sys_clk_en, 1'b0);
        pin(8'h03);
        wt(0, 1, 300);
        rng(143, 148);
        $display("wake test done");
        for (int s = 0; s < 4; s++) begin
            apb(1, `REG_CTRL, 32'h4 | s);
            apb(1, `REG_WDT_CLR, 0);
            wt(1, 1, 17000);
            rng(per[s] - 3, per[s] + 2);
            wt(1, 0, 1100);
            apb(0, `REG_STATUS, 0);
            chk(rd & 32'h4, 32'h4);
        end
        apb(1, `REG_CTRL, 32'h7);
        repeat (3) begin
            repeat (200) @(posedge pclk);
            apb(1, `REG_WDT_CLR, 0);
        end
        chk(chip_reset, 1'b0);
        $display("watchdog test done");
        apb(1, `REG_CTRL, 32'h10);
        pin(8'hDF);
        wt(1, 1, 4);
        rng(0, 4);
        pin(8'hFF);
        wt(1, 0, 1100);
        $display("reset pin test done");
        conclude();
    end
endmodule // sleep_wakeup_watchdog_ctrl_tb_top
`default_nettype wire
